// ==== design/fifo_host_pkg.sv ====
/*
  Package for the host-side controller of a handshaked register-array FIFO.
  Holds timing figures, derived cycle counts and the data width.
  Assumes a 40 MHz system clock.
*/
package fifo_host_pkg;
  // ****************************************
  // Widths and clock
  // ****************************************
  localparam int WORD_W        = 4;
  localparam int CLK_PERIOD_PS = 25000;
  localparam int FIFO_DEPTH    = 64;
  // ****************************************
  // Timing figures in picoseconds
  // ****************************************
  localparam int SI_ACK_PS      = 40000;    // Shift-in to input-ready low
  localparam int SI_REL_PS      = 40000;    // Shift-in fall to input-ready high
  localparam int SO_ACK_PS      = 45000;    // Shift-out to output-ready low
  localparam int SO_REL_PS      = 50000;    // Shift-out fall to output-ready high
  localparam int DATA_SETTLE_PS = 45000;    // Output word settle after output-ready rise
  localparam int FALLTHROUGH_PS = 1600000;  // Fallthrough and bubblethrough time
  localparam int STROBE_PS      = 33333;    // Half period at 15 MHz
  // ****************************************
  // Derived cycle counts
  // ****************************************
  function automatic int cycles_up(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int SI_ACK_CYC      = cycles_up(SI_ACK_PS);
  localparam int SO_ACK_CYC      = cycles_up(SO_ACK_PS);
  localparam int DATA_SETTLE_CYC = cycles_up(DATA_SETTLE_PS);
  localparam int FALLTHROUGH_CYC = cycles_up(FALLTHROUGH_PS);
  localparam int STROBE_CYC      = cycles_up(STROBE_PS);
  localparam int CNT_W           = 7;
  localparam logic [CNT_W-1:0] STROBE_CNT = CNT_W'(STROBE_CYC);
  localparam logic [CNT_W-1:0] SETTLE_CNT = CNT_W'(DATA_SETTLE_CYC + 1);
  localparam logic [CNT_W-1:0] TIMEOUT_CNT = CNT_W'(FALLTHROUGH_CYC + 2);
  localparam int CLEAR_CYC       = 4;
  localparam logic [CNT_W-1:0] CLEAR_CNT = CNT_W'(CLEAR_CYC);
endpackage

// ==== design/skid_buffer.sv ====
/*
  Two-entry buffer with valid/ready on both sides.
  Assumes a single clock, synchronous active-high reset and a clock enable.
*/
module skid_buffer
  import fifo_host_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic [WORD_W-1:0] in_data,
  input  wire logic              in_valid,
  output logic                   in_ready,
  output logic      [WORD_W-1:0] out_data,
  output logic                   out_valid,
  input  wire logic              out_ready
);
  // ****************************************
  // Storage
  // ****************************************
  logic [WORD_W-1:0] mem_r   [2];
  logic [WORD_W-1:0] mem_nxt [2];
  logic              wp_r, wp_nxt, rp_r, rp_nxt;
  logic [1:0]        cnt_r, cnt_nxt;
  logic              push, pop;

  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    mem_nxt = mem_r;
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wp_r] = in_data;
      wp_nxt        = ~wp_r;
    end
    if (pop) begin
      rp_nxt = ~rp_r;
    end
    cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mem_r[0] <= '0;
      mem_r[1] <= '0;
      wp_r     <= 1'b0;
      rp_r     <= 1'b0;
      cnt_r    <= 2'h0;
    end else if (ce) begin
      mem_r <= mem_nxt;
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// ==== design/fifo_host.sv ====
/*
  Host controller for a clockless 64-word register-array FIFO with two-edge
  shift-in/shift-out handshakes and an active-low master clear.
  Assumes device pins are synchronous to clk (40 MHz) and the device meets
  its own acknowledge and ripple timing.
*/
// Function
// - Take a word only while output-ready is high, via a shift-out pulse.
// - Do not trust output data at the output-ready rising edge.
// - Delay shift-out rise until own data setup on outputs is met.
// - Shift-out may be a fixed-width pulse rather than acknowledge-driven.
// - Pulse master clear low after power-up, then wait for input-ready.
module fifo_host
  import fifo_host_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  // Producer side
  input  wire logic [WORD_W-1:0] src_data,
  input  wire logic              src_valid,
  output logic                   src_ready,
  // Consumer side
  output logic      [WORD_W-1:0] snk_data,
  output logic                   snk_valid,
  input  wire logic              snk_ready,
  // Device pins
  output logic                   master_clear_n,
  output logic                   shift_in,
  output logic      [WORD_W-1:0] write_word_in,
  input  wire logic              input_ready,
  output logic                   shift_out,
  input  wire logic              output_ready,
  input  wire logic [WORD_W-1:0] read_word_out,
  // Status
  output logic                   dev_full,
  output logic                   dev_empty
);
  // ****************************************
  // Types and state
  // ****************************************
  typedef enum logic [1:0] {W_IDLE, W_HIGH, W_LOW} wr_st_t;
  typedef enum logic [2:0] {R_IDLE, R_SETTLE, R_HIGH, R_LOW, R_HOLD} rd_st_t;

  logic              clr_busy_r, clr_busy_nxt;
  logic [CNT_W-1:0]  clr_cnt_r, clr_cnt_nxt;
  logic              mclr_r, mclr_nxt;

  wr_st_t            wst_r, wst_nxt;
  logic [CNT_W-1:0]  wcnt_r, wcnt_nxt;
  logic [CNT_W-1:0]  wto_r, wto_nxt;
  logic              si_r, si_nxt;
  logic [WORD_W-1:0] wd_r, wd_nxt;
  logic              full_r, full_nxt;
  logic              src_ready_r, src_ready_nxt;

  rd_st_t            rst_r, rst_nxt;
  logic [CNT_W-1:0]  rcnt_r, rcnt_nxt;
  logic [CNT_W-1:0]  rto_r, rto_nxt;
  logic              so_r, so_nxt;
  logic              empty_r, empty_nxt;
  logic [WORD_W-1:0] bd_data;
  logic              b_valid, b_ready;
  logic              b_out_valid;
  logic [WORD_W-1:0] b_out_data;
  logic [WORD_W-1:0] sd_r, sd_nxt;
  logic              sv_r, sv_nxt;

  function automatic logic [CNT_W-1:0] dec_sat(input logic [CNT_W-1:0] v);
    return (v == '0) ? v : v - CNT_W'(1);
  endfunction

  // ****************************************
  // Master clear
  // ****************************************
  always_comb begin
    clr_busy_nxt = clr_busy_r;
    clr_cnt_nxt  = clr_cnt_r;
    mclr_nxt     = mclr_r;
    if (clr_busy_r) begin
      clr_cnt_nxt = dec_sat(clr_cnt_r);
      if (clr_cnt_r == '0) begin
        clr_busy_nxt = 1'b0;
        mclr_nxt     = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clr_busy_r <= 1'b1;
      clr_cnt_r  <= CLEAR_CNT;
      mclr_r     <= 1'b0;
    end else if (ce) begin
      clr_busy_r <= clr_busy_nxt;
      clr_cnt_r  <= clr_cnt_nxt;
      mclr_r     <= mclr_nxt;
    end
  end

  // ****************************************
  // Write side
  // ****************************************
  always_comb begin
    wst_nxt  = wst_r;
    wcnt_nxt = dec_sat(wcnt_r);
    wto_nxt  = dec_sat(wto_r);
    si_nxt   = si_r;
    wd_nxt   = wd_r;
    full_nxt = full_r;
    case (wst_r)
      W_IDLE: begin
        if (src_valid && src_ready_r) begin
          wd_nxt   = src_data;
          si_nxt   = 1'b1;
          wst_nxt  = W_HIGH;
          wcnt_nxt = STROBE_CNT;
          full_nxt = 1'b0;
        end
      end
      W_HIGH: begin
        if (!input_ready && wcnt_r == '0) begin
          si_nxt   = 1'b0;
          wst_nxt  = W_LOW;
          wcnt_nxt = STROBE_CNT;
          wto_nxt  = TIMEOUT_CNT;
        end
      end
      W_LOW: begin
        // No input-ready within a bubblethrough time means full
        if (input_ready) begin
          wst_nxt = W_IDLE;
        end else if (wto_r == '0) begin
          full_nxt = 1'b1;
          wst_nxt  = W_IDLE;
        end
      end
      default: wst_nxt = W_IDLE;
    endcase
    if (input_ready) begin
      full_nxt = 1'b0;
    end
    // Strobe only while input-ready is high, never into a full device
    src_ready_nxt = (wst_nxt == W_IDLE) && !clr_busy_nxt && input_ready
                    && (wcnt_nxt == '0);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wst_r  <= W_IDLE;
      wcnt_r <= '0;
      wto_r  <= '0;
      si_r   <= 1'b0;
      wd_r   <= '0;
      full_r <= 1'b0;
      src_ready_r <= 1'b0;
    end else if (ce) begin
      wst_r  <= wst_nxt;
      wcnt_r <= wcnt_nxt;
      wto_r  <= wto_nxt;
      si_r   <= si_nxt;
      wd_r   <= wd_nxt;
      full_r <= full_nxt;
      src_ready_r <= src_ready_nxt;
    end
  end

  // ****************************************
  // Read side
  // ****************************************
  always_comb begin
    rst_nxt   = rst_r;
    rcnt_nxt  = dec_sat(rcnt_r);
    rto_nxt   = dec_sat(rto_r);
    so_nxt    = so_r;
    empty_nxt = empty_r;
    b_valid   = 1'b0;
    bd_data   = read_word_out;
    case (rst_r)
      R_IDLE: begin
        // Wait out settle time after output-ready rises before sampling
        if (!clr_busy_r && output_ready && rcnt_r == '0) begin
          rst_nxt  = R_SETTLE;
          rcnt_nxt = SETTLE_CNT;
          empty_nxt = 1'b0;
        end
      end
      R_SETTLE: begin
        if (rcnt_r == '0 && b_ready) begin
          b_valid  = 1'b1;
          so_nxt   = 1'b1;
          rst_nxt  = R_HIGH;
          rcnt_nxt = STROBE_CNT;
        end
      end
      R_HIGH: begin
        // Fixed-width pulse also bounded below by the acknowledge
        if (!output_ready && rcnt_r == '0) begin
          so_nxt   = 1'b0;
          rst_nxt  = R_LOW;
          rcnt_nxt = STROBE_CNT;
          rto_nxt  = TIMEOUT_CNT;
        end
      end
      R_LOW: begin
        if (output_ready && rcnt_r == '0) begin
          rst_nxt = R_IDLE;
        end else if (rto_r == '0) begin
          empty_nxt = 1'b1;
          rst_nxt   = R_IDLE;
        end
      end
      default: rst_nxt = R_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rst_r   <= R_IDLE;
      rcnt_r  <= '0;
      rto_r   <= '0;
      so_r    <= 1'b0;
      empty_r <= 1'b1;
    end else if (ce) begin
      rst_r   <= rst_nxt;
      rcnt_r  <= rcnt_nxt;
      rto_r   <= rto_nxt;
      so_r    <= so_nxt;
      empty_r <= empty_nxt;
    end
  end

  // ****************************************
  // Buffer and registered consumer port
  // ****************************************
  // Sampled word waits here so a stalled consumer loses nothing
  skid_buffer u_buf (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .in_data   (bd_data),
    .in_valid  (b_valid),
    .in_ready  (b_ready),
    .out_data  (b_out_data),
    .out_valid (b_out_valid),
    .out_ready (!sv_r || snk_ready)
  );

  always_comb begin
    sd_nxt = sd_r;
    sv_nxt = sv_r;
    if (!sv_r || snk_ready) begin
      sv_nxt = b_out_valid;
      if (b_out_valid) begin
        sd_nxt = b_out_data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sd_r <= '0;
      sv_r <= 1'b0;
    end else if (ce) begin
      sd_r <= sd_nxt;
      sv_r <= sv_nxt;
    end
  end

  assign master_clear_n = mclr_r;
  assign shift_in       = si_r;
  assign write_word_in  = wd_r;
  assign shift_out      = so_r;
  assign snk_data       = sd_r;
  assign snk_valid      = sv_r;
  assign dev_full       = full_r;
  assign dev_empty      = empty_r;
  assign src_ready      = src_ready_r;
endmodule

// ==== sim/fifo_host_monitor.sv ====
/*
  Checker for the device-side strobe pins of fifo_host.
  Assumes one clock, clk, and the synchronous active-high reset rst.
*/
module fifo_host_checker
  import fifo_host_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              master_clear_n,
  input wire logic              shift_in,
  input wire logic [WORD_W-1:0] write_word_in,
  input wire logic              input_ready,
  input wire logic              shift_out,
  input wire logic              output_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // Handshake properties
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_si_needs_ready:
    assert property ($rose(shift_in) |-> $past(input_ready)) else $error("early shift-in");
  a_so_after_settle:
    assert property ($rose(shift_out) |-> $past(output_ready) && $past(output_ready, 3))
    else $error("shift-out before data settled");
  a_si_waits_ack:
    assert property (shift_in && input_ready |=> shift_in) else $error("shift-in dropped early");
  a_si_min_high:
    assert property ($rose(shift_in) |=> shift_in) else $error("shift-in pulse too short");
  a_si_min_low:
    assert property ($fell(shift_in) |=> !shift_in) else $error("shift-in gap too short");
  a_so_min_high:
    assert property ($rose(shift_out) |=> shift_out) else $error("shift-out pulse too short");
  a_so_min_low:
    assert property ($fell(shift_out) |=> !shift_out) else $error("shift-out gap too short");
  a_word_held:
    assert property (shift_in && $past(shift_in) |-> $stable(write_word_in))
    else $error("input word moved during strobe");
  a_clear_pulse:
    assert property ($fell(rst) |-> !master_clear_n [*3] ##[1:8] master_clear_n)
    else $error("clear pulse wrong");
  a_quiet_in_clear:
    assert property (!master_clear_n |-> !shift_in && !shift_out) else $error("strobe in clear");
endmodule

bind fifo_host fifo_host_checker chk (
  .clk(clk), .rst(rst), .master_clear_n(master_clear_n), .shift_in(shift_in),
  .write_word_in(write_word_in), .input_ready(input_ready), .shift_out(shift_out),
  .output_ready(output_ready)
);

// ==== sim/fifo_dev_model.sv ====
/*
  Behavioural 64-word register-array FIFO device with two-edge handshakes.
  Assumes pins move on clk edges; lag sets fallthrough and bubblethrough cycles.
*/
module fifo_dev_model
  import fifo_host_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              master_clear_n,
  input  wire logic              shift_in,
  input  wire logic [WORD_W-1:0] write_word_in,
  input  wire logic              shift_out,
  input  wire logic [6:0]        lag,
  output logic                   input_ready,
  output logic                   output_ready,
  output logic      [WORD_W-1:0] read_word_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // Stage array and handshakes
  // ****************************************
  logic [WORD_W-1:0] words[$];
  int                born[$];
  int                now = 0;
  int                hold_off = 0;
  logic              si_d, so_d, shown, taken, rearm, settle;
  always @(posedge clk) begin
    now++;
    si_d <= shift_in;
    so_d <= shift_out;
    if (!master_clear_n) begin
      words = {};
      born = {};
      {input_ready, output_ready} <= 2'b00;
      {shown, taken, settle, rearm} = 4'b0001;
      hold_off = 0;
    end else begin
      if (shift_in && !si_d && input_ready) begin
        words.push_back(write_word_in);
        born.push_back(now);
        input_ready <= 1'b0;
      end
      if (!shift_in && si_d) rearm = 1'b1;
      if (hold_off > 0) hold_off--;
      // Room alone is not enough when full: the gap must bubble back first
      if (rearm && !shift_in && words.size() < FIFO_DEPTH && hold_off == 0) begin
        input_ready <= 1'b1;
        rearm = 1'b0;
      end
      if (shift_out && !so_d && output_ready) begin
        output_ready <= 1'b0;
        taken = 1'b1;
      end
      if (!shift_out && so_d && taken) begin
        if (words.size() == FIFO_DEPTH) hold_off = lag;
        void'(words.pop_front());
        void'(born.pop_front());
        {shown, taken} = 2'b00;
      end
      // Word settles one cycle after ready rises, never trusted at the edge
      if (settle) read_word_out <= words[0];
      settle = 1'b0;
      if (!shown && !shift_out && words.size() > 0 && now - born[0] >= lag) begin
        read_word_out <= ~words[0];
        output_ready <= 1'b1;
        {shown, settle} = 2'b11;
      end
    end
  end
endmodule

// ==== sim/fifo_host_tb.sv ====
/*
  Self-checking bench for fifo_host against the behavioural FIFO device.
  Assumes fifo_dev_model and the checker bound to fifo_host.
*/
module fifo_host_tb
  import fifo_host_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // Signals, clock and checks
  // ****************************************
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              src_valid = 1'b0;
  logic              snk_ready = 1'b0;
  logic              acc = 1'b0;
  logic [WORD_W-1:0] src_data = '0;
  logic [6:0]        lag = 7'h01;
  logic [15:0]       lfsr = 16'h96BD;
  logic              src_ready, snk_valid, master_clear_n, shift_in, input_ready;
  logic              shift_out, output_ready, dev_full, dev_empty;
  logic [WORD_W-1:0] snk_data, write_word_in, read_word_out;
  logic [WORD_W-1:0] sent[$];
  int                num_errors = 0;
  int                total_checks = 0;
  int                cycles = 0;

  fifo_host dut (
    .clk(clk), .rst(rst), .ce(1'b1), .src_data(src_data), .src_valid(src_valid),
    .src_ready(src_ready), .snk_data(snk_data), .snk_valid(snk_valid),
    .snk_ready(snk_ready), .master_clear_n(master_clear_n), .shift_in(shift_in),
    .write_word_in(write_word_in), .input_ready(input_ready), .shift_out(shift_out),
    .output_ready(output_ready), .read_word_out(read_word_out), .dev_full(dev_full),
    .dev_empty(dev_empty)
  );
  fifo_dev_model dev (
    .clk(clk), .master_clear_n(master_clear_n), .shift_in(shift_in),
    .write_word_in(write_word_in), .shift_out(shift_out), .lag(lag),
    .input_ready(input_ready), .output_ready(output_ready), .read_word_out(read_word_out)
  );

  always #12.5 clk = ~clk;

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic check_word(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Words leave in the order they went in; expected order kept in sent
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
    acc = src_valid && src_ready === 1'b1;
    if (acc) sent.push_back(src_data);
    if (snk_valid === 1'b1 && snk_ready) begin
      check_flag(sent.size() > 0, 1'b1);
      if (sent.size() > 0) check_word(snk_data, sent.pop_front());
    end
  end

  // Producer holds its word until taken; push forces a word, slow lag in fill
  task automatic step(input logic push, input logic rd);
    @(posedge clk);
    #2;
    lfsr = lfsr_next(lfsr);
    if (acc || !src_valid) begin
      src_valid = lfsr[0] | push;
      src_data = lfsr[7:4];
    end
    snk_ready = rd;
    lag = push ? 7'h40 : {3'b000, lfsr[11:8]} + 7'h01;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    #2;
    rst = 1'b0;
    check_flag(master_clear_n, 1'b0);
    check_flag(dev_empty, 1'b1);
    repeat (3000) step(1'b0, lfsr[1] | lfsr[2]);
    repeat (900) step(1'b1, 1'b0);
    check_flag(dev_full, 1'b1);
    check_flag(src_ready, 1'b0);
    // Last offered word stays up until taken, once the drain frees room
    snk_ready = 1'b1;
    while (src_valid) begin
      @(posedge clk);
      #2;
      if (acc) src_valid = 1'b0;
    end
    for (int i = 0; i < 8000 && sent.size() > 0; i++) @(posedge clk);
    repeat (80) @(posedge clk);
    #2;
    check_flag(sent.size() == 0, 1'b1);
    check_flag(dev_empty, 1'b1);
    check_flag(dev_full, 1'b0);
    wrap_up();
  end
endmodule
